// ---- design/timer_compare_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the compare unit
`ifndef TIMER_COMPARE_DEFS_SVH
`define TIMER_COMPARE_DEFS_SVH
`define OFS_COMPARE_CONTROL  8'h00
`define OFS_COMPARE_VALUE    8'h04
`define OFS_TIMER_COUNT      8'h08
`define OFS_FLAG             8'h0c
`define OFS_ENABLE           8'h10
`define OFS_INTERRUPT_CTRL   8'h14
`define OFS_ADC_CTRL         8'h18
`define OFS_PORT_C_DIR       8'h1c
`define OFS_TIMER_CTRL       8'h20
`define BIT_TIMER_OVF        0
`define BIT_COMPARE_MATCH    2
`define BIT_PERIPH_IRQ_EN    6
`define BIT_PIN_DIR          2
`define FLAG_MASK            8'h05
`define RST_PORT_C_DIR       8'hff
`define RST_ZERO8            8'h00
`define RST_ZERO16           16'h0000
`define TICK_DIV_DEFAULT     1
`endif

// ---- design/timer_compare_pkg.sv ----
// Types shared by the compare unit files
package timer_compare_pkg;
  typedef enum logic [3:0] {
    MODE_OFF      = 4'h0,
    MODE_SET_PIN  = 4'h8,
    MODE_CLR_PIN  = 4'h9,
    MODE_SOFT_IRQ = 4'ha,
    MODE_TRIGGER  = 4'hb
  } compare_mode_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } bus_req_t;
endpackage : timer_compare_pkg

// ---- design/timer_pair.sv ----
// Sixteen-bit timer pair with prescale tick, bus load and special-event clear
`include "timer_compare_defs.svh"
module timer_pair #(
  parameter int TICK_DIV = `TICK_DIV_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        clear_i,
  // Status
  output logic [15:0]      count_o,
  output logic             ovf_o
);
  logic [15:0] div_q;
  logic [15:0] count_q;
  logic        ovf_q;
  wire         tick    = run_i && (div_q == 16'(TICK_DIV - 1));
  wire         wrap    = tick && (count_q == 16'hffff);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || tick) begin
      div_q <= `RST_ZERO16;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Clear beats load and count, and never reports an overflow
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_q <= `RST_ZERO16;
      ovf_q   <= 1'b0;
    end else begin
      ovf_q <= wrap && !load_i;
      if (load_i) begin
        count_q <= load_val_i;
      end else if (tick) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  assign count_o = count_q;
  assign ovf_o   = ovf_q;
endmodule : timer_pair

// ---- design/timer_compare_unit.sv ----
// Compare unit: Wishbone registers, timer match, pin latch, special event and interrupt
`include "timer_compare_defs.svh"
module timer_compare_unit
  import timer_compare_pkg::*;
#(
  parameter int TICK_DIV = `TICK_DIV_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt and converter start
  output logic             irq_o,
  output logic             adc_start_o,
  // Compare output pin
  output logic             compare_output_pin_o,
  output logic             compare_output_oe_o
);
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  bus_req_t req;
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};

  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  compare_control_reg_q;
  logic [15:0] compare_value_reg_q;
  logic [7:0]  flag_q;
  logic [7:0]  flag_d;
  logic [7:0]  enable_q;
  logic [7:0]  interrupt_control_reg_q;
  logic        adc_enable_q;
  logic [7:0]  port_c_direction_q;
  logic        timer_run_q;
  logic        latch_q;
  logic        latch_d;
  logic        eq_q;
  logic        adc_start_q;
  logic        irq_q;
  logic        oe_q;
  logic [15:0] timer_one_count;
  logic        timer_one_ovf;

  // Bus decode
  wire         access   = wb_cyc_i && wb_stb_i && !ack_q;
  wire         wr       = access && req.we;
  wire         wr_ctrl  = wr && (req.adr == `OFS_COMPARE_CONTROL);
  wire         wr_cval  = wr && (req.adr == `OFS_COMPARE_VALUE);
  wire         wr_tmr   = wr && (req.adr == `OFS_TIMER_COUNT);
  wire         wr_flag  = wr && (req.adr == `OFS_FLAG);
  wire         wr_en    = wr && (req.adr == `OFS_ENABLE);
  wire         wr_intc  = wr && (req.adr == `OFS_INTERRUPT_CTRL);
  wire         wr_adc   = wr && (req.adr == `OFS_ADC_CTRL);
  wire         wr_dir   = wr && (req.adr == `OFS_PORT_C_DIR);
  wire         wr_trun  = wr && (req.adr == `OFS_TIMER_CTRL);
  wire [31:0]  ctrl_new = merge_bytes({24'h0, compare_control_reg_q}, req.dat, req.sel);
  wire [31:0]  cval_new = merge_bytes({16'h0, compare_value_reg_q}, req.dat, req.sel);
  wire [31:0]  tmr_new  = merge_bytes({16'h0, timer_one_count}, req.dat, req.sel);
  wire [7:0]   w1c      = (wr_flag && req.sel[0]) ? (req.dat[7:0] & `FLAG_MASK) : 8'h00;
  wire         ctrl_zero_wr = wr_ctrl && (ctrl_new[7:0] == 8'h00);

  // Mode decode; unlisted codes leave compare off
  wire [3:0]   compare_mode_select = compare_control_reg_q[3:0];
  wire         mode_set  = compare_mode_select == MODE_SET_PIN;
  wire         mode_clr  = compare_mode_select == MODE_CLR_PIN;
  wire         mode_soft = compare_mode_select == MODE_SOFT_IRQ;
  wire         mode_trig = compare_mode_select == MODE_TRIGGER;
  wire         cmp_active = mode_set || mode_clr || mode_soft || mode_trig;

  // Equality is level; only its rising edge is an event, so a stopped timer
  // sitting on the compare value does not refire every cycle.
  wire         eq       = cmp_active && (compare_value_reg_q == timer_one_count);
  wire         match_ev = eq && !eq_q;
  wire         special  = match_ev && mode_trig;

  // Register read mux; unmapped offsets read zero
  logic [31:0] rd_data;
  always_comb begin
    unique case (req.adr)
      `OFS_COMPARE_CONTROL: rd_data = {24'h0, compare_control_reg_q};
      `OFS_COMPARE_VALUE:   rd_data = {16'h0, compare_value_reg_q};
      `OFS_TIMER_COUNT:     rd_data = {16'h0, timer_one_count};
      `OFS_FLAG:            rd_data = {24'h0, flag_q};
      `OFS_ENABLE:          rd_data = {24'h0, enable_q};
      `OFS_INTERRUPT_CTRL:  rd_data = {24'h0, interrupt_control_reg_q};
      `OFS_ADC_CTRL:        rd_data = {31'h0, adc_enable_q};
      `OFS_PORT_C_DIR:      rd_data = {24'h0, port_c_direction_q};
      `OFS_TIMER_CTRL:      rd_data = {31'h0, timer_run_q};
      default:              rd_data = 32'h0;
    endcase
  end

  // Pin latch: a control clear wins over a match in the same cycle
  always_comb begin
    latch_d = latch_q;
    if (ctrl_zero_wr) begin
      latch_d = 1'b0;
    end else if (match_ev && mode_set) begin
      latch_d = 1'b1;
    end else if (match_ev && mode_clr) begin
      latch_d = 1'b0;
    end
  end

  // Sticky flags: a set in the clearing cycle survives
  always_comb begin
    flag_d = flag_q & ~w1c;
    flag_d[`BIT_COMPARE_MATCH] = flag_d[`BIT_COMPARE_MATCH] | match_ev;
    flag_d[`BIT_TIMER_OVF]     = flag_d[`BIT_TIMER_OVF] | timer_one_ovf;
  end

  timer_pair #(
    .TICK_DIV (TICK_DIV)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (timer_run_q),
    .load_i     (wr_tmr),
    .load_val_i (tmr_new[15:0]),
    .clear_i    (special),
    .count_o    (timer_one_count),
    .ovf_o      (timer_one_ovf)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= access;
      dat_q <= access ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_control_reg_q   <= `RST_ZERO8;
      compare_value_reg_q     <= `RST_ZERO16;
      enable_q                <= `RST_ZERO8;
      interrupt_control_reg_q <= `RST_ZERO8;
      adc_enable_q            <= 1'b0;
      port_c_direction_q      <= `RST_PORT_C_DIR;
      timer_run_q             <= 1'b0;
    end else begin
      if (wr_ctrl) compare_control_reg_q <= {2'b00, ctrl_new[5:0]};
      if (wr_cval) compare_value_reg_q <= cval_new[15:0];
      if (wr_en && req.sel[0]) enable_q <= req.dat[7:0] & `FLAG_MASK;
      if (wr_intc && req.sel[0]) interrupt_control_reg_q <= req.dat[7:0];
      if (wr_adc && req.sel[0]) adc_enable_q <= req.dat[0];
      if (wr_dir && req.sel[0]) port_c_direction_q <= req.dat[7:0];
      if (wr_trun && req.sel[0]) timer_run_q <= req.dat[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q      <= `RST_ZERO8;
      latch_q     <= 1'b0;
      eq_q        <= 1'b0;
      adc_start_q <= 1'b0;
      irq_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      flag_q      <= flag_d;
      latch_q     <= latch_d;
      eq_q        <= eq;
      adc_start_q <= special && adc_enable_q;
      irq_q       <= interrupt_control_reg_q[`BIT_PERIPH_IRQ_EN] &&
                     |(flag_q & enable_q);
      oe_q        <= !port_c_direction_q[`BIT_PIN_DIR];
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = dat_q;
  assign irq_o                = irq_q;
  assign adc_start_o          = adc_start_q;
  assign compare_output_pin_o = latch_q;
  assign compare_output_oe_o  = oe_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence special_hit;
    match_ev && mode_trig;
  endsequence
  sequence timer_restarted;
    timer_one_count == 16'h0000 && !timer_one_ovf;
  endsequence

  AST_MATCH_FLAG: assert property (match_ev |=> flag_q[`BIT_COMPARE_MATCH])
    else $error("match did not set the flag");
  AST_SET_PIN: assert property (match_ev && mode_set && !wr_ctrl |=> compare_output_pin_o)
    else $error("set mode did not drive pin high");
  AST_CLR_PIN: assert property (match_ev && mode_clr |=> !compare_output_pin_o)
    else $error("clear mode did not drive pin low");
  AST_SOFT_HOLD: assert property (mode_soft && !wr_ctrl |=> $stable(compare_output_pin_o))
    else $error("software mode moved the pin");
  AST_CTRL_CLEAR: assert property (ctrl_zero_wr |=> !compare_output_pin_o)
    else $error("control clear left pin latch high");
  AST_TIMER_CLEAR: assert property (special_hit |=> timer_restarted)
    else $error("special event did not restart the timer cleanly");
  AST_ADC_START: assert property (special_hit ##0 adc_enable_q |=> adc_start_o ##1 !adc_start_o)
    else $error("converter start missing or not one cycle");
  AST_ADC_GATED: assert property (!adc_enable_q |=> !adc_start_o)
    else $error("converter started while disabled");
  AST_IRQ_GATE: assert property (!interrupt_control_reg_q[`BIT_PERIPH_IRQ_EN] |=> !irq_o)
    else $error("interrupt raised without peripheral enable");
  AST_IRQ_RAISE: assert property (match_ev && enable_q[`BIT_COMPARE_MATCH] &&
                   interrupt_control_reg_q[`BIT_PERIPH_IRQ_EN] && !w1c[`BIT_COMPARE_MATCH]
                   && !wr_en && !wr_intc |=> ##1 irq_o)
    else $error("enabled match did not raise interrupt");
  AST_MODE_OFF: assert property (!cmp_active |-> !match_ev)
    else $error("match while compare disabled");
  AST_MATCH_DETECT: assert property (cmp_active && !eq_q &&
                   compare_value_reg_q == timer_one_count |=> flag_q[`BIT_COMPARE_MATCH])
    else $error("equality not detected");

  // Bus handshake: one registered ack per taken request, data only beside it
  sequence bus_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence bus_answered;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_BUS_ACK: assert property (
    bus_taken |=> bus_answered)
    else $error("request not answered by a single ack");
  AST_DAT_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data shown without ack");

  // Pin direction and pin latch
  AST_OE_ON: assert property (!port_c_direction_q[`BIT_PIN_DIR] |=> compare_output_oe_o)
    else $error("pin not driven with direction bit clear");
  AST_OE_OFF: assert property (port_c_direction_q[`BIT_PIN_DIR] |=> !compare_output_oe_o)
    else $error("pin driven with direction bit set");
  AST_PIN_QUIET: assert property (
    !match_ev && !ctrl_zero_wr |=> $stable(compare_output_pin_o))
    else $error("pin latch moved without a match");
  AST_MODE_OFF_PIN: assert property (
    !cmp_active && !ctrl_zero_wr |=> $stable(compare_output_pin_o))
    else $error("pin latch moved while compare disabled");
  AST_SOFT_FLAG: assert property (
    match_ev && mode_soft && !wr_ctrl |=> flag_q[`BIT_COMPARE_MATCH] &&
    $stable(compare_output_pin_o))
    else $error("software mode match mishandled");

  // Flags, interrupt and converter start
  AST_FLAG_STICKY: assert property (
    flag_q[`BIT_COMPARE_MATCH] && !w1c[`BIT_COMPARE_MATCH] |=> flag_q[`BIT_COMPARE_MATCH])
    else $error("match flag lost without a clear");
  AST_MODE_OFF_FLAG: assert property (
    !cmp_active && !w1c[`BIT_COMPARE_MATCH] |=>
    flag_q[`BIT_COMPARE_MATCH] == $past(flag_q[`BIT_COMPARE_MATCH]))
    else $error("match flag moved while compare disabled");
  AST_OVF_FLAG: assert property (timer_one_ovf |=> flag_q[`BIT_TIMER_OVF])
    else $error("timer wrap did not set the overflow flag");
  AST_IRQ_LEVEL: assert property (
    interrupt_control_reg_q[`BIT_PERIPH_IRQ_EN] && |(flag_q & enable_q) |=> irq_o)
    else $error("enabled pending flag gave no interrupt");
  AST_IRQ_QUIET: assert property (
    !(|(flag_q & enable_q)) |=> !irq_o)
    else $error("interrupt without an enabled pending flag");
  AST_START_MODE: assert property (!mode_trig |=> !adc_start_o)
    else $error("converter start outside trigger mode");
  AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o)
    else $error("converter start longer than one cycle");
endmodule : timer_compare_unit

// ---- sim/adc_start_monitor.sv ----
// Converter-start side: counts start pulses and the gap between them
module adc_start_monitor (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Start strobe from the unit
  input  wire logic start_i,
  output int        pulses,
  output int        gap
);
  timeunit 1ns;
  timeprecision 1ns;
  int run;
  // A converter only reacts to starts it sees; it never answers back
  always @(posedge clk_i) begin
    run <= run + 1;
    if (rst_i) begin
      pulses <= 0;
      run <= 0;
    end else if (start_i === 1'b1) begin
      pulses <= pulses + 1;
      gap <= run + 1;
      run <= 0;
    end
  end
endmodule : adc_start_monitor

// ---- sim/testbench.sv ----
// Testbench for the compare unit: bus tasks, compare modes and special event
`include "timer_compare_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_compare_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i;
  logic        wb_ack_o, irq_o, adc_start_o, pin_o, oe_o;
  int          n_fail, checks_done, pulses, gap, p0, k;
  int          cyc_n = 0;

  // Timer runs off the core clock, never as an asynchronous counter
  timer_compare_unit #(.TICK_DIV(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .adc_start_o(adc_start_o), .compare_output_pin_o(pin_o), .compare_output_oe_o(oe_o));
  adc_start_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .start_i(adc_start_o),
    .pulses(pulses), .gap(gap));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold everything until ack is sampled, then idle one cycle
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // Only the bench timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (pin_o !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_pin

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // A hang ends the run; the whole sequence needs well under 3000 cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'({pin_o, oe_o, irq_o}), 32'h0);
    xfer(1'b0, `OFS_PORT_C_DIR, 32'h0);
    check(rd, 32'h000000ff);
    xfer(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, `OFS_PORT_C_DIR, 32'h000000fb);
    check(32'(oe_o), 32'h1);
    $display("done: reset and pin direction");
    xfer(1'b1, `OFS_ENABLE, 32'h04);
    xfer(1'b1, `OFS_INTERRUPT_CTRL, 32'h40);
    xfer(1'b1, `OFS_COMPARE_VALUE, 32'h0030);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_SET_PIN));
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    xfer(1'b1, `OFS_TIMER_CTRL, 32'h1);
    wait_pin(1'b1);
    check(32'(pin_o), 32'h1);
    @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    xfer(1'b1, `OFS_FLAG, 32'h05);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_CLR_PIN));
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    wait_pin(1'b0);
    check(32'(pin_o), 32'h0);
    $display("done: set and clear on match");
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_SET_PIN));
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    wait_pin(1'b1);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'h0);
    check(32'(pin_o), 32'h0);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_SET_PIN));
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    wait_pin(1'b1);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_SOFT_IRQ));
    xfer(1'b1, `OFS_FLAG, 32'h05);
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    k = 0;
    do begin
      xfer(1'b0, `OFS_FLAG, 32'h0);
      k++;
    end while (rd[2] !== 1'b1 && k < 60);
    check(rd & 32'h4, 32'h4);
    check(32'(pin_o), 32'h1);
    $display("done: control clear and software interrupt");
    xfer(1'b1, `OFS_INTERRUPT_CTRL, 32'h00);
    check(32'(irq_o), 32'h0);
    xfer(1'b1, `OFS_INTERRUPT_CTRL, 32'h40);
    check(32'(irq_o), 32'h1);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'h0);
    xfer(1'b1, `OFS_FLAG, 32'h04);
    check(32'(irq_o), 32'h0);
    $display("done: peripheral enable");
    xfer(1'b1, `OFS_ADC_CTRL, 32'h1);
    xfer(1'b1, `OFS_COMPARE_VALUE, 32'h0020);
    xfer(1'b1, `OFS_TIMER_COUNT, 32'h0);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_TRIGGER));
    xfer(1'b1, `OFS_FLAG, 32'h05);
    p0 = pulses;
    k = 0;
    while (pulses < p0 + 2 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    check(32'(gap), 32'h21);
    xfer(1'b0, `OFS_TIMER_COUNT, 32'h0);
    check(32'(rd <= 32'h20), 32'h1);
    xfer(1'b0, `OFS_FLAG, 32'h0);
    check(rd & 32'h5, 32'h4);
    // Converter off: matches keep clearing the timer but start nothing
    xfer(1'b1, `OFS_ADC_CTRL, 32'h0);
    p0 = pulses;
    repeat (110) @(posedge clk_i);
    check(32'(pulses), 32'(p0));
    $display("done: special event trigger");
    // A real wrap must flag overflow, a trigger clear at the top must not
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'h0);
    xfer(1'b1, `OFS_FLAG, 32'h05);
    xfer(1'b1, `OFS_TIMER_COUNT, 32'hfff0);
    repeat (40) @(posedge clk_i);
    xfer(1'b0, `OFS_FLAG, 32'h0);
    check(rd & 32'h1, 32'h1);
    xfer(1'b1, `OFS_COMPARE_VALUE, 32'hffff);
    xfer(1'b1, `OFS_TIMER_COUNT, 32'hffe0);
    xfer(1'b1, `OFS_COMPARE_CONTROL, 32'(MODE_TRIGGER));
    xfer(1'b1, `OFS_FLAG, 32'h05);
    repeat (40) @(posedge clk_i);
    xfer(1'b0, `OFS_FLAG, 32'h0);
    check(rd & 32'h5, 32'h4);
    xfer(1'b0, `OFS_TIMER_COUNT, 32'h0);
    check(32'(rd < 32'h40), 32'h1);
    $display("done: overflow flag against trigger clear");
    wrap_up();
  end
endmodule : testbench
